/* File: verilog/scd_pkg.sv */
package scd_pkg;

  // ****************************************************************
  // Widths and framing
  // ****************************************************************
  localparam int SCD_BYTE_W = 8;
  localparam int SCD_CNT_W = 24;
  localparam int SCD_FIFO_W = 8;
  localparam int SCD_FIFO_D = 32;
  localparam logic [7:0] SCD_PREAMBLE = 8'hb5;
  localparam logic [7:0] SCD_POSTAMBLE = 8'h4e;
  localparam logic [2:0] SCD_BIT_LAST = 3'h7;
  localparam logic [2:0] SCD_BIT_ZERO = 3'h0;
  localparam logic [4:0] SCD_HDR_BITS = 5'h18;
  localparam logic [SCD_CNT_W-1:0] SCD_CNT_ONE = 24'h000001;

  // Slave parallel: first byte on 2nd rising edge, then every 8th
  localparam logic [2:0] SCD_FIRST_EDGE = 3'h2;

  // ****************************************************************
  // Link timing
  // ****************************************************************
  localparam real SCD_CLK_NS = 4.0;
  localparam real SCD_SINGLE_MAX_MHZ = 10.0;
  localparam real SCD_CHAIN_MAX_MHZ = 1.0;
  localparam int SCD_SINGLE_MIN_CYC = int'($ceil(1000.0 / SCD_SINGLE_MAX_MHZ / SCD_CLK_NS));

  typedef enum logic {SCD_MODE_SERIAL, SCD_MODE_PARALLEL} scd_mode_type;

  typedef enum {
    SCD_INIT,
    SCD_PREAMBLE_WAIT,
    SCD_LENGTH,
    SCD_LOAD,
    SCD_FORWARD,
    SCD_DONE_WAIT,
    SCD_STARTUP,
    SCD_ERROR
  } scd_state_type;

  typedef struct packed {
    logic data_in;
    logic config_clock;
    logic [SCD_BYTE_W-1:0] byte_bus;
    logic done_in;
    logic prog_n;
  } scd_pins_type;

  typedef struct packed {
    logic serial_out;
    logic done_oe_n;
    logic check_err_oe_n;
    logic config_phase_high;
    logic startup;
  } scd_outs_type;

endpackage

/* File: verilog/scd_fifo.sv */
`timescale 1ns/1ps
module scd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk, // Clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic flush, // Empty the buffer
  input wire logic in_valid, // Word offered
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Word in
  output logic out_valid, // Word available
  input wire logic out_ready, // Word taken
  output logic [WIDTH-1:0] out_data // Word out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } scd_fifo_state_type;

  scd_fifo_state_type st_r;
  scd_fifo_state_type st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign out_valid = st_r.wr != st_r.rd;
  assign in_ready = (st_r.wr[AW] == st_r.rd[AW]) || (st_r.wr[AW-1:0] != st_r.rd[AW-1:0]);
  assign out_data = mem[st_r.rd[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb
  begin
    st_nxt = st_r;
    if (push)
    begin
      st_nxt.wr = st_r.wr + 1'b1;
    end
    if (pop)
    begin
      st_nxt.rd = st_r.rd + 1'b1;
    end
    if (flush)
    begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
    if (push)
    begin
      mem[st_r.wr[AW-1:0]] <= in_data;
    end
  end
endmodule

/* File: verilog/scd_loader.sv */
// Function
// - Slave serial mode captures one bit per config clock from the serial input.
// - After own memory is full, further input bits are forwarded downstream until frame count reaches length.
// - Downstream devices are slave serial; each serial output feeds next input.
// - Parallel-driven serial inputs load identical configurations in several devices.
// - Slave parallel mode ignores both chip select inputs.
// - Slave parallel mode samples a whole byte on a rising config clock edge.
// - First byte is captured on second rising edge after phase output rises.
// - Later bytes are captured every eighth rising edge; host keeps that cadence.
// - Serialized bits appear on serial output half a clock after capture.
// - After preamble, serial output is held high until forwarding starts.
// - On postamble, memory is full and the done output is released.
// - Keep loading and forwarding until frame count reaches length or done rises.
// - Done is released on completion; shared line is wired-AND.
// - When the shared done line rises, enter start-up together.
// - In slave modes config clock is an input shared by the chain.
// - Capture on rising config clock edge, update serial output on falling edge.
// - Bad preamble drives the check error line low in a device that is not the lead.
// - Lead device with a check error drops the phase output, restarting load.
// - Phase output low in initialization, high during configuration.
// - Done held low during configuration, released once configuration completes.
// - Bytes are serialized starting with bit zero.
`timescale 1ns/1ps
module scd_loader
  import scd_pkg::*;
(
  input wire logic ref_clk, // Block clock, 250 MHz
  input wire logic resetn, // Synchronous reset, active low
  input wire scd_mode_type mode, // Serial or parallel slave mode
  input wire logic is_lead, // This device heads the chain
  input wire logic config_clock, // Link clock from the host
  input wire logic serial_config_in, // Serial data in
  input wire logic [SCD_BYTE_W-1:0] config_byte_bus, // Byte data in
  input wire logic chip_select_high, // Not used in slave modes
  input wire logic chip_select_low, // Not used in slave modes
  input wire logic program_request_low, // Restart request, active low
  input wire logic done_in, // Shared done line level
  output logic done_out, // Done pin output value (always 0)
  output logic done_oe_n, // Done pin enable, low drives low
  output logic check_error_low_out, // Check error output value (always 0)
  output logic check_error_low_oe_n, // Check error enable, low drives low
  output logic config_phase_high, // Phase output, high while configuring
  output logic serial_config_out, // Serial data out
  output logic startup, // Start-up state reached
  output logic [SCD_BYTE_W-1:0] cfg_word, // Loaded configuration word
  output logic cfg_word_valid, // Word valid
  input wire logic cfg_word_ready // Sink accepts word
);
  typedef struct packed {
    scd_pins_type s1;
    scd_pins_type s2;
    logic clk_d;
    scd_state_type st;
    logic [2:0] edge_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [SCD_BYTE_W-1:0] pbyte;
    logic [3:0] pleft;
    logic [SCD_CNT_W-1:0] len;
    logic [SCD_CNT_W-1:0] frame_cnt;
    logic [4:0] hdr_cnt;
    logic out_pend;
    logic out_bit;
    logic full;
    scd_outs_type o;
    logic [SCD_BYTE_W-1:0] word;
    logic word_v;
  } scd_loader_state_type;

  scd_loader_state_type r_r;
  scd_loader_state_type r_nxt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [SCD_FIFO_W-1:0] fifo_out_data;

  // ****************************************************************
  // Word buffer towards the configuration memory
  // ****************************************************************
  scd_fifo #(.WIDTH(SCD_FIFO_W), .DEPTH(SCD_FIFO_D)) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .flush(r_r.st == SCD_INIT),
    .in_valid(r_r.word_v),
    .in_ready(fifo_in_ready),
    .in_data(r_r.word),
    .out_valid(fifo_out_valid),
    .out_ready(cfg_word_ready),
    .out_data(fifo_out_data)
  );

  // ****************************************************************
  // Loader state
  // ****************************************************************
  always_comb
  begin
    logic rise;
    logic fall;
    logic bit_v;
    logic b;
    logic [7:0] sh;
    rise = 1'b0;
    fall = 1'b0;
    bit_v = 1'b0;
    b = 1'b0;
    sh = 8'h00;
    r_nxt = r_r;
    r_nxt.s1 = '{serial_config_in, config_clock, config_byte_bus, done_in, program_request_low};
    r_nxt.s2 = r_r.s1;
    r_nxt.clk_d = r_r.s2.config_clock;
    rise = r_r.s2.config_clock && !r_r.clk_d;
    fall = !r_r.s2.config_clock && r_r.clk_d;
    if (r_r.word_v && fifo_in_ready)
    begin
      r_nxt.word_v = 1'b0;
    end
    // Bit source: serial pin or serialized byte, LSB first
    if (rise && r_r.st != SCD_INIT && r_r.st != SCD_STARTUP && r_r.st != SCD_ERROR)
    begin
      if (mode == SCD_MODE_SERIAL)
      begin
        bit_v = 1'b1;
        b = r_r.s2.data_in;
      end
      else
      begin
        // Chip selects deliberately unread
        if (r_r.edge_cnt != SCD_BIT_LAST)
        begin
          r_nxt.edge_cnt = r_r.edge_cnt + 3'h1;
        end
        if (r_r.pleft != 4'h0)
        begin
          bit_v = 1'b1;
          b = r_r.pbyte[3'(4'h8 - r_r.pleft)];
          r_nxt.pleft = r_r.pleft - 4'h1;
        end
        // A capture overrides the countdown so the new byte is not lost
        if (r_r.edge_cnt == SCD_FIRST_EDGE - 3'h1 || r_r.edge_cnt == SCD_BIT_LAST)
        begin
          if (r_r.pleft == 4'h0 || r_r.pleft == 4'h1)
          begin
            r_nxt.pbyte = r_r.s2.byte_bus;
            r_nxt.pleft = 4'h8;
            r_nxt.edge_cnt = SCD_BIT_ZERO;
          end
        end
      end
    end
    sh = {b, r_r.shreg[7:1]};
    if (bit_v)
    begin
      unique case (r_r.st)
        SCD_PREAMBLE_WAIT:
        begin
          r_nxt.shreg = sh;
          if (r_r.bit_cnt == SCD_BIT_LAST)
          begin
            r_nxt.bit_cnt = SCD_BIT_ZERO;
            if (sh == SCD_PREAMBLE)
            begin
              r_nxt.st = SCD_LENGTH;
              r_nxt.o.serial_out = 1'b1;
            end
            else
            begin
              r_nxt.st = SCD_ERROR;
            end
          end
          else
          begin
            r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
          end
        end
        SCD_LENGTH:
        begin
          r_nxt.len = {b, r_r.len[SCD_CNT_W-1:1]};
          r_nxt.hdr_cnt = r_r.hdr_cnt + 5'h1;
          if (r_r.hdr_cnt == SCD_HDR_BITS - 5'h1)
          begin
            r_nxt.st = SCD_LOAD;
            r_nxt.frame_cnt = '0;
          end
        end
        SCD_LOAD:
        begin
          r_nxt.shreg = sh;
          r_nxt.frame_cnt = r_r.frame_cnt + SCD_CNT_ONE;
          r_nxt.bit_cnt = r_r.bit_cnt + 3'h1;
          if (r_r.bit_cnt == SCD_BIT_LAST)
          begin
            if (sh == SCD_POSTAMBLE)
            begin
              r_nxt.full = 1'b1;
              r_nxt.o.done_oe_n = 1'b1;
              r_nxt.st = SCD_FORWARD;
            end
            else
            begin
              r_nxt.word = sh;
              r_nxt.word_v = 1'b1;
            end
          end
        end
        SCD_FORWARD:
        begin
          r_nxt.frame_cnt = r_r.frame_cnt + SCD_CNT_ONE;
          r_nxt.out_pend = 1'b1;
          r_nxt.out_bit = b;
          if (r_nxt.frame_cnt == r_r.len)
          begin
            r_nxt.st = SCD_DONE_WAIT;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Serial output changes on the falling link edge
    if (fall && r_r.out_pend)
    begin
      r_nxt.o.serial_out = r_r.out_bit;
      r_nxt.out_pend = 1'b0;
    end
    // Shared done high ends loading and starts everyone together
    if (r_r.full && r_r.s2.done_in && r_r.st != SCD_STARTUP)
    begin
      r_nxt.st = SCD_STARTUP;
    end
    if (r_r.st == SCD_INIT)
    begin
      r_nxt.st = SCD_PREAMBLE_WAIT;
      r_nxt.o.config_phase_high = 1'b1;
      r_nxt.edge_cnt = SCD_BIT_ZERO;
      r_nxt.bit_cnt = SCD_BIT_ZERO;
      r_nxt.pleft = 4'h0;
      r_nxt.hdr_cnt = 5'h00;
    end
    if (r_nxt.st == SCD_STARTUP)
    begin
      r_nxt.o.startup = 1'b1;
    end
    if (r_nxt.st == SCD_ERROR)
    begin
      if (is_lead)
      begin
        r_nxt.st = SCD_INIT;
        r_nxt.o.config_phase_high = 1'b0;
      end
      else
      begin
        r_nxt.o.check_err_oe_n = 1'b0;
      end
    end
    if (!r_r.s2.prog_n)
    begin
      r_nxt.st = SCD_INIT;
      r_nxt.edge_cnt = SCD_BIT_ZERO;
      r_nxt.bit_cnt = SCD_BIT_ZERO;
      r_nxt.pleft = 4'h0;
      r_nxt.hdr_cnt = 5'h00;
      r_nxt.full = 1'b0;
      r_nxt.out_pend = 1'b0;
      r_nxt.word_v = 1'b0;
      r_nxt.o = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      r_r <= '0;
      r_r.o <= '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
      r_r.st <= SCD_INIT;
      // Request pin idles high; avoids a false restart after reset
      r_r.s1.prog_n <= 1'b1;
      r_r.s2.prog_n <= 1'b1;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign done_out = 1'b0;
  assign check_error_low_out = 1'b0;
  assign done_oe_n = r_r.o.done_oe_n;
  assign check_error_low_oe_n = r_r.o.check_err_oe_n;
  assign config_phase_high = r_r.o.config_phase_high;
  assign serial_config_out = r_r.o.serial_out;
  assign startup = r_r.o.startup;
  assign cfg_word = fifo_out_data;
  assign cfg_word_valid = fifo_out_valid;
endmodule

/* File: test/scd_loader_checker.sv */
`timescale 1ns/1ps
module scd_loader_checker
  import scd_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic is_lead, // Lead device
  input wire logic config_clock, // Link clock pin
  input wire logic program_request_low, // Restart request
  input wire logic done_in, // Shared done line
  input wire logic done_out, // Done value
  input wire logic done_oe_n, // Done enable
  input wire logic check_error_low_out, // Error value
  input wire logic check_error_low_oe_n, // Error enable
  input wire logic config_phase_high, // Phase output
  input wire logic serial_config_out, // Serial out
  input wire logic startup // Start-up reached
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_reset_state: assert property
    (disable iff (1'b0) !resetn |=> !config_phase_high && !startup && !done_oe_n)
    else $error("outputs wrong after reset");
  a_prog_abandon: assert property
    (!program_request_low [*8] |-> !config_phase_high && !startup)
    else $error("request low did not return to init");
  a_dout_on_fall: assert property
    ($changed(serial_config_out) && config_phase_high |-> !config_clock)
    else $error("serial out changed while link clock high");
  a_startup_done: assert property
    ($rose(startup) |-> done_oe_n && done_in)
    else $error("start-up without shared done high");
  a_done_release: assert property
    ($rose(done_oe_n) |-> config_phase_high && !startup)
    else $error("done released outside configuration");
  a_err_slave_only: assert property
    ($fell(check_error_low_oe_n) |-> !is_lead ##1 !check_error_low_oe_n [*4])
    else $error("error line misdriven");
  a_phase_drop: assert property
    ($fell(config_phase_high) |-> is_lead || !program_request_low || !check_error_low_oe_n)
    else $error("phase dropped without cause");
  a_open_drain: assert property
    (done_out == 1'b0 && check_error_low_out == 1'b0)
    else $error("open-drain value not low");
  c_startup: cover property ($rose(startup));
  c_error: cover property ($fell(check_error_low_oe_n));
  c_done: cover property ($rose(done_oe_n));
endmodule

bind scd_loader scd_loader_checker i_scd_loader_checker (.ref_clk(ref_clk), .resetn(resetn),
  .is_lead(is_lead), .config_clock(config_clock), .program_request_low(program_request_low),
  .done_in(done_in), .done_out(done_out), .done_oe_n(done_oe_n),
  .check_error_low_out(check_error_low_out), .check_error_low_oe_n(check_error_low_oe_n),
  .config_phase_high(config_phase_high), .serial_config_out(serial_config_out),
  .startup(startup));

/* File: test/scd_host_model.sv */
`timescale 1ns/1ps
module scd_host_model
  import scd_pkg::*;
(
  output logic config_clock, // Link clock, still between frames
  output logic serial_config_in, // Serial data
  output logic [SCD_BYTE_W-1:0] config_byte_bus // Byte data
);
  // ****************************************************************
  // Link driver, 48 ns period
  // ****************************************************************
  initial
  begin
    config_clock = 1'b0;
    serial_config_in = 1'b1;
    config_byte_bus = 8'h00;
  end
  task automatic pulse();
    #24 config_clock = 1'b1;
    #24 config_clock = 1'b0;
  endtask
  task automatic send_bit(input logic b);
    serial_config_in = b;
    pulse();
    serial_config_in = ~b;
  endtask
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      send_bit(v[i]);
  endtask
  task automatic send_par(input logic [7:0] v[]);
    config_byte_bus = ~v[0];
    pulse();
    foreach (v[k])
    begin
      config_byte_bus = v[k];
      repeat (k == 0 ? 1 : 8) pulse();
    end
    config_byte_bus = ~config_byte_bus;
    repeat (8) pulse();
  endtask
endmodule

/* File: test/slave_config_daisy_chain_bench.sv */
`timescale 1ns/1ps
module slave_config_daisy_chain_bench;
  import scd_pkg::*;
  // ****************************************************************
  // Wiring
  // ****************************************************************
  logic ref_clk, resetn, is_lead, cs_h, cs_l, prog_n, chain_rel;
  scd_mode_type mode;
  logic done_out, done_oe_n, ce_out, ce_oe_n, phase, sout, startup, word_v;
  logic cclk, sdin, done_line, word_rdy;
  logic [7:0] bus, word;
  logic [7:0] got[$];
  int n_fail, cmp_count, cycles, n_fall;
  assign done_line = (done_oe_n ? 1'b1 : done_out) & chain_rel;
  scd_host_model i_host (.config_clock(cclk), .serial_config_in(sdin), .config_byte_bus(bus));
  scd_loader i_scd_loader (.ref_clk(ref_clk), .resetn(resetn), .mode(mode), .is_lead(is_lead),
    .config_clock(cclk), .serial_config_in(sdin), .config_byte_bus(bus),
    .chip_select_high(cs_h), .chip_select_low(cs_l), .program_request_low(prog_n),
    .done_in(done_line), .done_out(done_out), .done_oe_n(done_oe_n),
    .check_error_low_out(ce_out), .check_error_low_oe_n(ce_oe_n), .config_phase_high(phase),
    .serial_config_out(sout), .startup(startup), .cfg_word(word), .cfg_word_valid(word_v),
    .cfg_word_ready(word_rdy));
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (word_v === 1'b1 && word_rdy === 1'b1) got.push_back(word);
  always @(negedge phase)
    n_fall++;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] b1(input logic v);
    return {7'h00, v};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic settle();
    repeat (6) @(negedge ref_clk);
  endtask
  task automatic wait_phase();
    for (int i = 0; i < 40 && phase !== 1'b1; i++)
      @(negedge ref_clk);
    check("phase high", b1(phase), 8'h01);
  endtask
  task automatic restart(input scd_mode_type m, input logic lead);
    @(negedge ref_clk);
    resetn = 1'b0;
    mode = m;
    is_lead = lead;
    chain_rel = 1'b0;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    wait_phase();
    got.delete();
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_serial();
    logic [7:0] fr[5] = '{8'h20, 8'h00, 8'h00, 8'ha1, 8'h5c};
    logic [7:0] fwd = 8'h3c;
    restart(SCD_MODE_SERIAL, 1'b1);
    i_host.send_byte(SCD_PREAMBLE);
    settle();
    check("dout after preamble", b1(sout), 8'h01);
    foreach (fr[i])
      i_host.send_byte(fr[i]);
    check("done held", b1(done_oe_n), 8'h00);
    i_host.send_byte(SCD_POSTAMBLE);
    settle();
    check("done released", b1(done_oe_n), 8'h01);
    check("word count", 8'(got.size()), 8'h02);
    check("word 0", got[0], 8'ha1);
    check("word 1", got[1], 8'h5c);
    for (int i = 0; i < 8; i++)
    begin
      i_host.send_bit(fwd[i]);
      settle();
      check("dout forward", b1(sout), b1(fwd[i]));
    end
    check("startup waits", b1(startup), 8'h00);
    chain_rel = 1'b1;
    settle();
    check("startup", b1(startup), 8'h01);
  endtask
  task automatic t_parallel();
    restart(SCD_MODE_PARALLEL, 1'b1);
    cs_h = 1'b0;
    cs_l = 1'b1;
    i_host.send_par('{8'hb5, 8'h18, 8'h00, 8'h00, 8'h1d, 8'h6a, 8'h4e});
    settle();
    check("par done", b1(done_oe_n), 8'h01);
    check("par count", 8'(got.size()), 8'h02);
    check("par word 0", got[0], 8'h1d);
    check("par word 1", got[1], 8'h6a);
  endtask
  task automatic t_err(input logic lead);
    int falls;
    restart(SCD_MODE_SERIAL, lead);
    falls = n_fall;
    i_host.send_byte(8'h00);
    settle();
    check("error enable", b1(ce_oe_n), b1(lead));
    check("phase dropped", b1(n_fall != falls), b1(lead));
    prog_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    check("phase in init", b1(phase), 8'h00);
    check("error freed", b1(ce_oe_n), 8'h01);
    prog_n = 1'b1;
    wait_phase();
  endtask
  task automatic t_fifo();
    restart(SCD_MODE_SERIAL, 1'b1);
    word_rdy = 1'b0;
    i_host.send_byte(SCD_PREAMBLE);
    for (int i = 0; i < 3; i++)
      i_host.send_byte(8'hff);
    for (int i = 0; i <= 32; i++)
      i_host.send_byte(8'(i));
    settle();
    check("fifo held", 8'(got.size()), 8'h00);
    check("fifo valid", b1(word_v), 8'h01);
    check("fifo head", word, 8'h00);
    word_rdy = 1'b1;
    repeat (40) @(negedge ref_clk);
    check("fifo count", 8'(got.size()), 8'h21);
    for (int i = 0; i <= 32; i++)
      check("fifo data", got[i], 8'(i));
    check("fifo empty", b1(word_v), 8'h00);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    {ref_clk, resetn, is_lead, cs_h, cs_l, chain_rel, word_rdy} = 7'h19;
    prog_n = 1'b1;
    mode = SCD_MODE_SERIAL;
    t_serial();
    t_parallel();
    t_err(1'b0);
    t_err(1'b1);
    t_fifo();
    print_verdict();
  end
endmodule
